// *** verilog/dbr_pkg.sv ***
// package of constants and carrier types for the dma bus request and reset block
// How it works
// - request output is active high for DMA
// - request raised automatically when FIFO needs service
// - reset enters reset mode immediately, asynchronously
// - no packets until start command bit set
// - reset sets command to 21h (stop bit set), clears mask, data, transmit config
// - internal reset completes within ten clocks
// - each DMA cycle takes four clocks, t1-t4
`default_nettype none
package dbr_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ            = 25000000;
  localparam int RESET_LIMIT_CYC   = 10;
  // internal init sweep; must stay within the reset limit
  localparam int INIT_CYC          = 8;
  localparam int DMA_PHASES        = 4;

  // ****************************************************************
  // reset values of the configuration registers held here
  // ****************************************************************
  localparam logic [7:0] CMD_RST   = 8'h21;
  localparam logic [7:0] IMASK_RST = 8'h00;
  localparam logic [7:0] DCFG_RST  = 8'h00;
  localparam logic [7:0] TCFG_RST  = 8'h00;
  localparam int         START_BIT = 1;
  localparam int         STOP_BIT  = 0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    DBR_PH_T1,
    DBR_PH_T2,
    DBR_PH_T3,
    DBR_PH_T4
  } dbr_phase_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] imask;
    logic [7:0] dcfg;
    logic [7:0] tcfg;
  } dbr_cfg_t;

  typedef struct packed {
    logic       we;
    logic [1:0] sel;
    logic [7:0] data;
  } dbr_wr_t;

endpackage
`default_nettype wire

// *** verilog/dbr_cfg_mem.sv ***
// small register store for the four reset-affected configuration registers
`default_nettype none
module dbr_cfg_mem (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  // control
  input  wire logic          init_en,
  input  wire dbr_pkg::dbr_wr_t wr,
  // contents
  output var  dbr_pkg::dbr_cfg_t cfg
);
  import dbr_pkg::*;

  // reset returns every register to its value immediately
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= '{cmd: CMD_RST, imask: IMASK_RST, dcfg: DCFG_RST, tcfg: TCFG_RST};
    end else if (init_en) begin
      cfg <= '{cmd: CMD_RST, imask: IMASK_RST, dcfg: DCFG_RST, tcfg: TCFG_RST};
    end else if (wr.we) begin
      case (wr.sel)
        2'h0:    cfg.cmd   <= wr.data;
        2'h1:    cfg.imask <= wr.data;
        2'h2:    cfg.dcfg  <= wr.data;
        default: cfg.tcfg  <= wr.data;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** verilog/dbr_top.sv ***
// bus request, grant handshake and reset sequencing of the dma engine
`default_nettype none
module dbr_top #(
  parameter int MAX_BURST = 8
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // system bus arbitration
  input  wire logic              bus_grant_in,
  output logic                   bus_request_out,
  output logic                   bus_own_out,
  output logic [1:0]             dma_phase_out,
  // fifo service
  input  wire logic              fifo_need_svc,
  input  wire logic [7:0]        fifo_words,
  output logic                   fifo_word_done,
  // configuration writes
  input  wire dbr_pkg::dbr_wr_t  cfg_wr,
  output logic                   start_command_bit,
  output logic                   net_enable,
  output logic                   init_busy,
  output dbr_pkg::dbr_cfg_t      cfg_out
);
  import dbr_pkg::*;

  // refuse settings the counters cannot serve
  if (MAX_BURST < 1 || MAX_BURST > 255) begin : g_bad_burst
    $error("MAX_BURST out of range");
  end
  // the output register adds one edge to the internal sweep
  if (INIT_CYC < 1 || INIT_CYC + 1 > RESET_LIMIT_CYC) begin : g_bad_init
    $error("init longer than reset limit");
  end

  // ****************************************************************
  // grant synchroniser: three stages, change counts when last two agree
  // ****************************************************************
  logic gnt_s1_r, gnt_s2_r, gnt_s3_r, gnt_r;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gnt_s1_r <= 1'b0;
      gnt_s2_r <= 1'b0;
      gnt_s3_r <= 1'b0;
      gnt_r    <= 1'b0;
    end else begin
      gnt_s1_r <= bus_grant_in;
      gnt_s2_r <= gnt_s1_r;
      gnt_s3_r <= gnt_s2_r;
      if (gnt_s2_r == gnt_s3_r) begin
        gnt_r <= gnt_s3_r;
      end
    end
  end

  // ****************************************************************
  // reset sequencing
  // ****************************************************************
  logic [3:0] init_cnt_r;
  logic       init_busy_r;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_cnt_r  <= 4'h0;
      init_busy_r <= 1'b1;
    end else if (init_busy_r) begin
      // finishes INIT_CYC edges after release, inside the limit
      if (init_cnt_r == 4'(INIT_CYC - 1)) begin
        init_busy_r <= 1'b0;
      end
      init_cnt_r <= init_cnt_r + 4'h1;
    end
  end

  // ****************************************************************
  // configuration store
  // ****************************************************************
  dbr_cfg_t cfg;
  dbr_wr_t  wr_gated;
  always_comb begin
    wr_gated    = cfg_wr;
    wr_gated.we = cfg_wr.we & ~init_busy_r;
  end

  dbr_cfg_mem u_cfg (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .init_en (init_busy_r),
    .wr      (wr_gated),
    .cfg     (cfg)
  );

  logic started;
  assign started = cfg.cmd[START_BIT] & ~cfg.cmd[STOP_BIT] & ~init_busy_r;

  // ****************************************************************
  // request / ownership machine
  // ****************************************************************
  typedef enum logic [1:0] {DBR_IDLE, DBR_REQ, DBR_OWN, DBR_REL} dbr_st_t;
  dbr_st_t    st_r;
  dbr_phase_t ph_r;
  logic [7:0] left_r;
  logic       req_r, own_r, done_r;
  logic       want_svc, take_req, last_t4, burst_end;

  // clip the fifo count to the longest burst the counter may hold
  function automatic logic [7:0] burst_len(input logic [7:0] words);
    return (words > 8'(MAX_BURST)) ? 8'(MAX_BURST) : words;
  endfunction

  // no request raised until started; packets stay idle
  assign want_svc  = started && fifo_need_svc && fifo_words != 8'h00;
  assign take_req  = (st_r == DBR_IDLE) && want_svc;
  assign last_t4   = (st_r == DBR_OWN) && (ph_r == DBR_PH_T4);
  // a lost grant also ends the burst at t4, so the bus is never kept
  assign burst_end = last_t4 && (left_r == 8'h01 || !gnt_r);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= DBR_IDLE;
    end else begin
      case (st_r)
        DBR_IDLE: begin
          if (take_req) begin
            st_r <= DBR_REQ;
          end
        end
        DBR_REQ: begin
          // request held until grant seen
          if (gnt_r) begin
            st_r <= DBR_OWN;
          end
        end
        DBR_OWN: begin
          if (burst_end) begin
            st_r <= DBR_REL;
          end
        end
        DBR_REL: begin
          // wait for grant to fall so a looped-back grant is not reused
          if (!gnt_r) begin
            st_r <= DBR_IDLE;
          end
        end
        default: begin
          st_r <= DBR_IDLE;
        end
      endcase
    end
  end

  // four phases per memory cycle, parked at t1 outside ownership
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_r <= DBR_PH_T1;
    end else if (st_r != DBR_OWN) begin
      ph_r <= DBR_PH_T1;
    end else begin
      case (ph_r)
        DBR_PH_T1: ph_r <= DBR_PH_T2;
        DBR_PH_T2: ph_r <= DBR_PH_T3;
        DBR_PH_T3: ph_r <= DBR_PH_T4;
        default:   ph_r <= DBR_PH_T1;
      endcase
    end
  end

  // words left in the burst, one taken at each t4
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      left_r <= 8'h00;
    end else if (take_req) begin
      left_r <= burst_len(fifo_words);
    end else if (last_t4) begin
      left_r <= left_r - 8'h01;
    end
  end

  // request stands from the fifo's call to the last word
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_r <= 1'b0;
    end else if (take_req) begin
      req_r <= 1'b1;
    end else if (burst_end) begin
      req_r <= 1'b0;
    end
  end

  // bus cycles begin only once the synchronised grant is high
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      own_r <= 1'b0;
    end else if (st_r == DBR_REQ && gnt_r) begin
      own_r <= 1'b1;
    end else if (burst_end) begin
      own_r <= 1'b0;
    end
  end

  // one pulse per word as its t4 closes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_r <= 1'b0;
    end else begin
      done_r <= last_t4;
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_command_bit <= 1'b0;
      net_enable        <= 1'b0;
      init_busy         <= 1'b1;
      cfg_out           <= '{cmd: CMD_RST, imask: IMASK_RST, dcfg: DCFG_RST, tcfg: TCFG_RST};
    end else begin
      start_command_bit <= cfg.cmd[START_BIT];
      net_enable        <= started;
      init_busy         <= init_busy_r;
      cfg_out           <= cfg;
    end
  end

  assign bus_request_out = req_r;
  assign bus_own_out     = own_r;
  assign dma_phase_out   = ph_r;
  assign fifo_word_done  = done_r;

endmodule
`default_nettype wire

// *** test/dbr_top_asserts.sv ***
// checker of the bus handshake and reset sequencing ports
`default_nettype none
module dbr_chk (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       arst_n,
  // watched ports
  input wire logic       bus_grant_in,
  input wire logic       bus_request_out,
  input wire logic       bus_own_out,
  input wire logic [1:0] dma_phase_out,
  input wire logic       fifo_need_svc,
  input wire logic       fifo_word_done,
  input wire logic       net_enable,
  input wire logic       init_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ****
  // sequences
  // ****
  sequence s_last_phase;
    bus_own_out && dma_phase_out == 2'h3;
  endsequence
  a_own_req: assert property (bus_own_out |-> bus_request_out)
    else $error("bus owned without request");
  a_req_cause: assert property ($rose(bus_request_out) |-> $past(fifo_need_svc && net_enable))
    else $error("request without cause");
  a_grant_first: assert property ($rose(bus_own_out) |-> $past(bus_grant_in, 2))
    else $error("bus taken without grant");
  a_reset_quiet: assert property ($rose(arst_n) |-> !bus_request_out && !bus_own_out && init_busy)
    else $error("outputs active out of reset");
  a_init_bound: assert property ($rose(arst_n) |-> ##[1:10] !init_busy)
    else $error("internal reset too long");
  a_phase_steps: assert property (bus_own_out && dma_phase_out != 2'h3 |=>
    bus_own_out && dma_phase_out == $past(dma_phase_out) + 2'h1)
    else $error("phase order broken");
  a_word_done: assert property (s_last_phase |=> fifo_word_done)
    else $error("no word pulse after t4");
  a_req_holds: assert property (bus_request_out && !bus_own_out |=> bus_request_out)
    else $error("request dropped early");
endmodule
bind dbr_top dbr_chk i_chk (.sys_clk, .arst_n, .bus_grant_in, .bus_request_out, .bus_own_out,
  .dma_phase_out, .fifo_need_svc, .fifo_word_done, .net_enable, .init_busy);
`default_nettype wire

// *** test/dbr_arb_model.sv ***
// arbiter model that answers the bus request after a chosen lag
`default_nettype none
module dbr_arb_model (
  // clock
  input  wire logic       sys_clk,
  // arbitration
  input  wire logic       req,
  input  wire logic [3:0] lag,
  output wire logic       grant
);
  timeunit 1ns;
  timeprecision 1ns;
  int   waited  = 0;
  logic grant_r = 1'b0;
  assign grant = grant_r;
  // grant falls with the request, never held high on its own
  always @(posedge sys_clk) begin
    waited  <= req ? waited + 1 : 0;
    grant_r <= #1 req && waited >= lag; // lag 0 acts as a looped request
  end
endmodule
`default_nettype wire

// *** test/test_dma_bus_request_and_reset.sv ***
// self-checking bench of the dma bus request and reset block
`default_nettype none
module test_dma_bus_request_and_reset;
  timeunit 1ns;
  timeprecision 1ns;
  import dbr_pkg::*;
  localparam int MAXB = 8;
  logic       sys_clk = 1'b0, arst_n = 1'b0, svc = 1'b0;
  logic       grant, req, own, done, busy, start_bit, net_en;
  logic [1:0] phase;
  logic [3:0] lag = 4'h0;
  logic [7:0] words = 8'h00;
  logic [7:0] cfg_m [4];
  logic [7:0] tbl [4] = '{8'h01, 8'h08, 8'h09, 8'h00};
  dbr_wr_t    wr = '0;
  dbr_cfg_t   cfg;
  int         fail_count = 0, checks = 0, n;
  always #20 sys_clk = ~sys_clk;
  dbr_top #(.MAX_BURST(MAXB)) i_dut (.sys_clk, .arst_n, .bus_grant_in(grant),
    .bus_request_out(req), .bus_own_out(own), .dma_phase_out(phase), .fifo_need_svc(svc),
    .fifo_words(words), .fifo_word_done(done), .cfg_wr(wr), .start_command_bit(start_bit),
    .net_enable(net_en), .init_busy(busy), .cfg_out(cfg));
  dbr_arb_model i_arb (.sys_clk, .req, .lag, .grant);
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d, fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic timed_out(input string what);
    fail_count++;
    $display("CHECK FAILED at %0t: %s timed out", $time, what);
    conclude();
  endtask
  task automatic do_reset;
    arst_n = 1'b0;
    tick(12);
    arst_n = 1'b1;
    for (n = 0; busy !== 1'b0 && n < 20; n++) tick(1);
    if (busy !== 1'b0) timed_out("reset");
    cmp(n <= 10, 1);
    cfg_m = '{CMD_RST, IMASK_RST, DCFG_RST, TCFG_RST};
    cmp(cfg, {cfg_m[0], cfg_m[1], cfg_m[2], cfg_m[3]});
    cmp(start_bit, CMD_RST[START_BIT]);
    cmp(net_en, 1'b0);
    $display("reset done");
  endtask
  task automatic wr_cfg(input logic [1:0] s, input logic [7:0] d);
    wr = '{1'b1, s, d};
    tick(1);
    wr = '0;
    cfg_m[s] = d;
    tick(2);
    cmp(cfg, {cfg_m[0], cfg_m[1], cfg_m[2], cfg_m[3]});
    cmp(start_bit, cfg_m[0][START_BIT]);
    cmp(net_en, cfg_m[0][START_BIT] && !cfg_m[0][STOP_BIT]);
    $display("cfg write %0d done", s);
  endtask
  task automatic xfer(input logic [7:0] w);
    int got = 0;
    bit seen = 0;
    bit on = cfg_m[0][START_BIT] && !cfg_m[0][STOP_BIT];
    lag = 4'($urandom_range(5));
    words = w;
    svc = 1'b1;
    for (n = 0; n < 150 && !(seen && req === 1'b0); n++) begin
      tick(1);
      seen |= req === 1'b1;
      got += int'(done === 1'b1);
    end
    if (on && w != 0 && !(seen && req === 1'b0)) timed_out("transfer");
    svc = 1'b0;
    repeat (8) begin
      tick(1);
      got += int'(done === 1'b1);
    end
    cmp(seen, on && w != 0);
    cmp(got, on ? (w > MAXB ? MAXB : w) : 0);
    $display("xfer %0d done", w);
  endtask
  initial begin
    void'($urandom(32'h0dd3));
    do_reset();
    xfer(8'h03);
    for (int s = 1; s < 4; s++) wr_cfg(2'(s), 8'($urandom));
    wr_cfg(2'h0, 8'h23);
    xfer(8'h02);
    wr_cfg(2'h0, 8'h22);
    for (int i = 0; i < 6; i++) xfer(i < 4 ? tbl[i] : 8'($urandom_range(12, 1)));
    // reset lands in mid-burst and must not wait for it
    lag = 4'h0;
    svc = 1'b1;
    words = 8'h08;
    tick(14);
    arst_n = 1'b0;
    svc = 1'b0;
    #2;
    cmp({req, own}, 0);
    do_reset();
    xfer(8'h04);
    conclude();
  end
endmodule
`default_nettype wire
